// >>> core/tcr_pkg.sv
package tcr_pkg;

    // ------------------------------------------------------------
    // register word offsets (word addresses on the avalon bus)
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_CNT_LO = 4'h0;
    localparam logic [3:0] OFS_CNT_HI = 4'h1;
    localparam logic [3:0] OFS_CTRL = 4'h2;
    localparam logic [3:0] OFS_FLAGS = 4'h3;
    localparam logic [3:0] OFS_ENABLES = 4'h4;
    localparam logic [3:0] OFS_PRIO = 4'h5;
    localparam logic [3:0] OFS_CMP_LO = 4'h6;
    localparam logic [3:0] OFS_CMP_HI = 4'h7;
    localparam logic [3:0] OFS_CMP_CFG = 4'h8;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CTRL_RUN = 0;
    localparam int CTRL_SRC = 1;
    localparam int CTRL_SYNC_OFF = 2;
    localparam int CTRL_SEL_LO = 3;
    localparam int CTRL_PS_LO = 4;
    localparam int CTRL_PS_HI = 5;
    localparam int CTRL_SEL_HI = 6;
    localparam int CTRL_WIDE = 7;
    localparam int FLAG_OVF = 1;
    localparam int CFG_U1_MODE = 0;
    localparam int CFG_U2_MODE = 4;

    // ------------------------------------------------------------
    // values
    // ------------------------------------------------------------
    localparam logic [3:0] MODE_SPECIAL_TRIG = 4'hb;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] CNT_MAX = 16'hffff;

endpackage : tcr_pkg

// >>> core/tcr_top.sv
// Overview of operation
// - 16-bit counter counts up from 0000 to ffff then wraps to zero.
// - overflow wrap sets sticky overflow flag at bit 1 of flags register.
// - overflow interrupt is forwarded only while enable bit 1 is set.
// - unit mode 1011 selecting this counter resets it on its trigger.
// - that trigger also starts a conversion, only when converter enabled.
// - trigger reset is not guaranteed in asynchronous counter mode.
// - with unit mode 1011, compare value acts as period: counter returns to zero at match.
// - counter low byte write coinciding with trigger wins over the reset.
// - trigger from unit two clears counter without setting overflow flag.
// - wide mode: low read latches high byte, low write loads it.
// - low byte writes and the trigger clear the prescaler, high writes do not.
module tcr_top (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic EXT_TICK,
    input wire logic ADC_ENABLED,
    output logic ADC_START,
    output logic SPECIAL_TRIGGER,
    output logic IRQ
);
    import tcr_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [15:0] cnt_ff, nxt_cnt;
    logic [7:0] hbuf_ff, nxt_hbuf;
    logic [7:0] ctrl_ff, nxt_ctrl;
    logic [7:0] flags_ff, nxt_flags;
    logic [7:0] enab_ff, nxt_enab;
    logic [7:0] prio_ff, nxt_prio;
    logic [15:0] cmp_ff, nxt_cmp;
    logic [7:0] cfg_ff, nxt_cfg;
    logic [2:0] ps_ff, nxt_ps;
    logic ack_ff, nxt_ack;
    logic [31:0] rdata_ff, nxt_rdata;
    logic adc_ff, nxt_adc;
    logic trig_ff, nxt_trig;

    // one wait cycle: the request is answered on its second edge
    logic req, acc, wr, rd;
    assign req = AVS_READ | AVS_WRITE;
    assign acc = req & ack_ff;
    assign wr = acc & AVS_WRITE;
    assign rd = acc & AVS_READ;
    assign AVS_WAITREQUEST = req & ~ack_ff;
    assign AVS_READDATA = rdata_ff;
    assign ADC_START = adc_ff;
    assign SPECIAL_TRIGGER = trig_ff;

    // ------------------------------------------------------------
    // register map, one byte per word index, upper bus bits read 0
    // ------------------------------------------------------------
    // 0 counter low byte: a write clears the prescaler and, in wide
    //   mode, also moves the high byte buffer into the counter
    // 1 counter high byte: in wide mode only the buffer is seen
    // 2 control: run, source, sync off, selects, prescale, wide
    // 3 flags: bit 1 is the sticky overflow flag, a read clears
    //   only the bits that the read returned
    // 4 enables: same layout as the flags, gates the irq line
    // 5 priority: stored for software, no effect on the logic
    // 6 compare low byte, 7 compare high byte
    // 8 unit modes: unit one in bits 3:0, unit two in bits 7:4
    // unmapped words read zero and ignore writes
    //
    // limitations a user must know:
    // - in asynchronous external mode the trigger is dropped, so
    //   a compare period only holds with a synchronous source
    // - a compare value of zero keeps matching while the counter
    //   sits at zero; software should program a nonzero period
    // - the external tick is taken as already synchronous, one
    //   increment per prescaled cycle in which it is high
    //
    // last prescaler count (divide by 1, 2, 4 or 8) from the two prescale bits
    function automatic logic [2:0] ps_last(input logic [1:0] sel);
        logic [2:0] r;
        r = 3'h0;
        unique case (sel)
            2'd0: r = 3'h0;
            2'd1: r = 3'h1;
            2'd2: r = 3'h3;
            2'd3: r = 3'h7;
        endcase
        return r;
    endfunction

    // unit mode field chooses the special event trigger
    function automatic logic is_trig(input logic [3:0] m);
        return m == MODE_SPECIAL_TRIG;
    endfunction

    // ------------------------------------------------------------
    // counting and trigger
    // ------------------------------------------------------------
    logic tick, inc, match, u1_sel, u2_sel, trig, u2_trig;
    logic wr_lo, wr_hi, wide;
    logic [1:0] pssel;

    assign wide = ctrl_ff[CTRL_WIDE];
    assign pssel = {ctrl_ff[CTRL_PS_HI], ctrl_ff[CTRL_PS_LO]};
    assign wr_lo = wr & (AVS_ADDRESS == OFS_CNT_LO);
    assign wr_hi = wr & (AVS_ADDRESS == OFS_CNT_HI);
    // external ticks are taken as already synchronous
    assign tick = ctrl_ff[CTRL_SRC] ? EXT_TICK : 1'b1;
    // counter holds while stopped
    assign inc = ctrl_ff[CTRL_RUN] & tick & (ps_ff == ps_last(pssel));
    // unit one serves this counter only when both selects are clear
    assign u1_sel = ~ctrl_ff[CTRL_SEL_HI] & ~ctrl_ff[CTRL_SEL_LO];
    // unit two serves it whenever either select is set
    assign u2_sel = ctrl_ff[CTRL_SEL_HI] | ctrl_ff[CTRL_SEL_LO];
    assign match = ctrl_ff[CTRL_RUN] & (cnt_ff == cmp_ff);
    // async counter mode drops the trigger
    logic trig_allowed;
    assign trig_allowed = ~(ctrl_ff[CTRL_SRC] & ctrl_ff[CTRL_SYNC_OFF]);
    assign u2_trig = u2_sel & is_trig(cfg_ff[CFG_U2_MODE +: 4]) & match;
    assign trig = trig_allowed & match & ((u1_sel &
        is_trig(cfg_ff[CFG_U1_MODE +: 4])) | u2_trig);

    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_ps = ps_ff;
        nxt_hbuf = hbuf_ff;
        nxt_trig = trig & ~wr_lo;
        nxt_adc = trig & ~wr_lo & ADC_ENABLED;
        if (ctrl_ff[CTRL_RUN] && tick) begin
            nxt_ps = (ps_ff == ps_last(pssel)) ? 3'h0 : ps_ff + 3'h1;
        end
        if (inc) begin
            nxt_cnt = cnt_ff + 16'h0001;
        end
        if (wr_lo) begin
            // write wins over a coincident trigger
            nxt_cnt[7:0] = AVS_WRITEDATA[7:0];
            if (wide) begin
                nxt_cnt[15:8] = hbuf_ff;
            end
            nxt_ps = 3'h0;
        end else if (trig) begin
            nxt_cnt = 16'h0000;
            nxt_ps = 3'h0;
        end
        if (wr_hi) begin
            // high write never touches the prescaler
            if (wide) begin
                nxt_hbuf = AVS_WRITEDATA[7:0];
            end else begin
                nxt_cnt[15:8] = AVS_WRITEDATA[7:0];
            end
        end
        if (rd && AVS_ADDRESS == OFS_CNT_LO && wide) begin
            nxt_hbuf = cnt_ff[15:8];
        end
    end

    // ------------------------------------------------------------
    // registers and bus
    // ------------------------------------------------------------
    logic ovf;
    // wrap counts only on increment; a unit two trigger never sets it
    // a low byte write in the same cycle replaces the wrap
    assign ovf = inc & (cnt_ff == CNT_MAX) & ~wr_lo;

    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_flags = flags_ff;
        nxt_enab = enab_ff;
        nxt_prio = prio_ff;
        nxt_cmp = cmp_ff;
        nxt_cfg = cfg_ff;
        if (wr) begin
            unique case (AVS_ADDRESS)
                OFS_CTRL: nxt_ctrl = AVS_WRITEDATA[7:0];
                OFS_ENABLES: nxt_enab = AVS_WRITEDATA[7:0];
                OFS_PRIO: nxt_prio = AVS_WRITEDATA[7:0];
                OFS_CMP_LO: nxt_cmp[7:0] = AVS_WRITEDATA[7:0];
                OFS_CMP_HI: nxt_cmp[15:8] = AVS_WRITEDATA[7:0];
                OFS_CMP_CFG: nxt_cfg = AVS_WRITEDATA[7:0];
                default: nxt_ctrl = ctrl_ff;
            endcase
        end
        // read of flags clears only what the snapshot returned
        if (rd && AVS_ADDRESS == OFS_FLAGS) begin
            nxt_flags = flags_ff & ~rdata_ff[7:0];
        end
        // set wins over the read clear
        if (ovf) begin
            nxt_flags[FLAG_OVF] = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // bus answer
    // ------------------------------------------------------------
    // read data is captured on the first edge of a read, so it
    // already stands at the edge where waitrequest is seen low
    logic rd_early;
    assign rd_early = AVS_READ & ~AVS_WRITE & ~ack_ff;

    always_comb begin
        nxt_ack = req & ~ack_ff;
        nxt_rdata = rdata_ff;
        if (rd_early) begin
            unique case (AVS_ADDRESS)
                OFS_CNT_LO: nxt_rdata = {24'h0, cnt_ff[7:0]};
                OFS_CNT_HI: nxt_rdata = {24'h0,
                    wide ? hbuf_ff : cnt_ff[15:8]};
                OFS_CTRL: nxt_rdata = {24'h0, ctrl_ff};
                OFS_FLAGS: nxt_rdata = {24'h0, flags_ff};
                OFS_ENABLES: nxt_rdata = {24'h0, enab_ff};
                OFS_PRIO: nxt_rdata = {24'h0, prio_ff};
                OFS_CMP_LO: nxt_rdata = {24'h0, cmp_ff[7:0]};
                OFS_CMP_HI: nxt_rdata = {24'h0, cmp_ff[15:8]};
                OFS_CMP_CFG: nxt_rdata = {24'h0, cfg_ff};
                default: nxt_rdata = 32'h0;
            endcase
        end
    end

    assign IRQ = |(flags_ff & enab_ff);

    // ------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------
    // counting group: counter, prescaler, buffer and trigger pulses
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            cnt_ff <= 16'h0000;
            hbuf_ff <= RST_BYTE;
            ps_ff <= 3'h0;
            adc_ff <= 1'b0;
            trig_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            hbuf_ff <= nxt_hbuf;
            ps_ff <= nxt_ps;
            adc_ff <= nxt_adc;
            trig_ff <= nxt_trig;
        end
    end

    // software register group
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            ctrl_ff <= RST_BYTE;
            flags_ff <= RST_BYTE;
            enab_ff <= RST_BYTE;
            prio_ff <= RST_BYTE;
            cmp_ff <= 16'h0000;
            cfg_ff <= RST_BYTE;
        end else begin
            ctrl_ff <= nxt_ctrl;
            flags_ff <= nxt_flags;
            enab_ff <= nxt_enab;
            prio_ff <= nxt_prio;
            cmp_ff <= nxt_cmp;
            cfg_ff <= nxt_cfg;
        end
    end

    // bus answer group: one wait cycle, then registered read data
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            ack_ff <= 1'b0;
            rdata_ff <= 32'h0;
        end else begin
            ack_ff <= nxt_ack;
            rdata_ff <= nxt_rdata;
        end
    end

endmodule // tcr_top

// >>> verification/tcr_chk.sv
module tcr_chk (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic AVS_WAITREQUEST,
    input wire logic ADC_ENABLED,
    input wire logic ADC_START,
    input wire logic SPECIAL_TRIGGER
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);
    logic req;
    // a request of either kind, both never high together
    assign req = AVS_READ | AVS_WRITE;
    a_wait_first: assert property ($rose(req) |-> AVS_WAITREQUEST)
        else $error("new request not held off");
    a_ack_next: assert property (req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
        else $error("request not answered next cycle");
    a_idle_nowait: assert property (!req |-> !AVS_WAITREQUEST)
        else $error("wait raised with no request");
    a_upper_zero: assert property (AVS_READDATA[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_data_stands: assert property (!AVS_READ |=> $stable(AVS_READDATA))
        else $error("read data moved without read");
    a_trig_pulse: assert property (SPECIAL_TRIGGER |=> !SPECIAL_TRIGGER)
        else $error("trigger longer than one cycle");
    a_conv_trig: assert property (ADC_START |-> SPECIAL_TRIGGER)
        else $error("conversion start without trigger");
    a_conv_gate: assert property (ADC_START |-> $past(ADC_ENABLED))
        else $error("conversion start while converter off");
    c_trig: cover property (SPECIAL_TRIGGER);
    c_conv: cover property (ADC_START);
    c_write: cover property (AVS_WRITE && !AVS_WAITREQUEST);
endmodule // tcr_chk

bind tcr_top tcr_chk u_chk (.CLK(CLK), .NRST(NRST), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .ADC_ENABLED(ADC_ENABLED),
    .ADC_START(ADC_START), .SPECIAL_TRIGGER(SPECIAL_TRIGGER));

// >>> verification/tcr_adc_model.sv
module tcr_adc_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic conv_on,
    input wire logic conv_start,
    input wire logic trig,
    output logic conv_enabled,
    output int n_conv,
    output int n_trig
);
    timeunit 1ns;
    timeprecision 1ns;
    // converter enable is registered, so it never changes on the edge it acts
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            conv_enabled <= 1'b0;
            n_conv <= 0;
            n_trig <= 0;
        end else begin
            conv_enabled <= conv_on;
            n_conv <= n_conv + int'(conv_start);
            n_trig <= n_trig + int'(trig);
        end
    end
endmodule // tcr_adc_model

// >>> verification/tcr_top_bench.sv
module tcr_top_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import tcr_pkg::*;
    logic clk = 0, nrst = 0, rd = 0, wr = 0, tick = 0, conv = 0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wd = 32'h0, rdat;
    logic wt, adcen, adcst, trig, irq;
    logic [7:0] d;
    int n_errors = 0, samples_checked = 0, nc, nt, conv_cnt, trig_cnt;
    // --------------------------------------------------------------
    // clock, design and converter model
    // --------------------------------------------------------------
    initial forever #5 clk = ~clk;
    tcr_top u_dut (.CLK(clk), .NRST(nrst), .AVS_ADDRESS(adr), .AVS_READ(rd),
        .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_READDATA(rdat),
        .AVS_WAITREQUEST(wt), .EXT_TICK(tick), .ADC_ENABLED(adcen),
        .ADC_START(adcst), .SPECIAL_TRIGGER(trig), .IRQ(irq));
    tcr_adc_model u_adc (.clk(clk), .nrst(nrst), .conv_on(conv),
        .conv_start(adcst), .trig(trig), .conv_enabled(adcen),
        .n_conv(conv_cnt), .n_trig(trig_cnt));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one bus cycle; waitrequest and read data are taken at the rising edge
    task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] v);
        int n;
        n = 0;
        @(posedge clk);
        adr <= a;
        wd <= {24'h0, v};
        rd <= !w;
        wr <= w;
        do begin
            @(posedge clk);
            n++;
        end while (wt !== 1'b0 && n < 50);
        if (n >= 50) n_errors++;
        d = rdat[7:0];
        rd <= 1'b0;
        wr <= 1'b0;
        @(negedge clk);
    endtask
    task automatic tally_and_finish;
        $display("checks=%0d errors=%0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // run needs well under 2000 cycles; the limit leaves wide margin
    initial begin
        #200000;
        n_errors++;
        tally_and_finish();
    end
    // --------------------------------------------------------------
    // tests
    // --------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        acc(0, OFS_CNT_LO, 0);
        chk(d, RST_BYTE);
        acc(1, OFS_CTRL, 8'h80);
        acc(1, OFS_CNT_HI, 8'h56);
        acc(1, OFS_CNT_LO, 8'h78);
        acc(1, OFS_CNT_HI, 8'h9a);
        acc(0, OFS_CNT_LO, 0);
        chk(d, 8'h78);
        acc(0, OFS_CNT_HI, 0);
        chk(d, 8'h56);
        acc(1, OFS_CTRL, 8'h00);
        acc(0, OFS_CNT_HI, 0);
        chk(d, 8'h56);
        acc(1, 4'hf, 8'h5a);
        acc(0, 4'hf, 0);
        chk(d, 8'h00);
        // start two steps short of the wrap
        acc(1, OFS_CNT_HI, 8'hff);
        acc(1, OFS_CNT_LO, 8'hfe);
        acc(1, OFS_ENABLES, 8'h02);
        acc(1, OFS_CTRL, 8'h01);
        repeat (8) @(posedge clk);
        @(negedge clk);
        chk(irq, 1);
        acc(1, OFS_ENABLES, 8'h00);
        chk(irq, 0);
        acc(1, OFS_ENABLES, 8'h02);
        chk(irq, 1);
        acc(0, OFS_FLAGS, 0);
        chk(d, 8'h02);
        acc(0, OFS_FLAGS, 0);
        chk(d, 8'h00);
        chk(irq, 0);
        acc(0, OFS_CNT_HI, 0);
        chk(d, 8'h00);
        // unit one with converter on, then unit two with converter off
        for (int k = 0; k < 2; k++) begin
            conv <= (k == 0);
            acc(1, OFS_CTRL, 8'h00);
            acc(1, OFS_CNT_LO, 8'h00);
            acc(1, OFS_CMP_LO, 8'h05);
            acc(1, OFS_CMP_HI, 8'h00);
            acc(0, OFS_FLAGS, 0);
            acc(1, OFS_CMP_CFG, k ? 8'hb0 : 8'h0b);
            nc = conv_cnt;
            nt = trig_cnt;
            acc(1, OFS_CTRL, k ? 8'h41 : 8'h01);
            repeat (40) @(posedge clk);
            acc(0, OFS_CNT_LO, 0);
            chk(d <= 8'h05, 1);
            chk(trig_cnt > nt, 1);
            chk(conv_cnt > nc, k == 0);
            acc(0, OFS_FLAGS, 0);
            chk(d, 8'h00);
        end
        // async external source: the trigger must stay quiet
        acc(1, OFS_CTRL, 8'h00);
        acc(1, OFS_CNT_LO, 8'h00);
        acc(1, OFS_CMP_CFG, 8'h0b);
        tick <= 1'b1;
        nt = trig_cnt;
        acc(1, OFS_CTRL, 8'h07);
        repeat (20) @(posedge clk);
        @(negedge clk);
        chk(trig_cnt == nt, 1);
        acc(0, OFS_CNT_LO, 0);
        chk(d > 8'h05, 1);
        tally_and_finish();
    end
endmodule // tcr_top_bench
